// ===== logic/tmr0_timer.sv
`include "tmr0_map.svh"
module tmr0_timer
  import tmr0_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Counting pin, sampled whatever its port direction
  input wire logic counter0_ext_clock_pin_in,
  // Prescaler taps for the second timer
  output logic [3:0] prescale_taps_out,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Interrupt
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Control, count, flag and mask state
  logic [2:0] sel;
  logic [7:0] counter0_value;
  logic flag_ovf;
  logic mask_ovf;
  logic half_mode;

  // Prescaler phase and count, shared with the second timer
  logic half_ph;
  logic [9:0] presc;

  // Pin sampling: two synchroniser stages and one delay for edges
  logic pin_s1;
  logic pin_s2;
  logic pin_d;

  // Bus holding slots; each keeps one beat until the write completes
  logic [31:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;

  // Read answer, chosen combinationally and registered on the take
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: in 24 MHz mode it advances every other cycle, giving 12 MHz
  // The same gate holds the taps and CK, so every internal source runs off the 12 MHz base
  wire presc_tick = !half_mode || half_ph;
  wire [9:0] presc_inc = presc + 10'h001;
  // A tap wraps when every prescaler bit up to its index is one
  wire [3:0] tap_wrap;
  assign tap_wrap[0] = presc_tick && (&presc[`TMR0_TAP8:0]);
  assign tap_wrap[1] = presc_tick && (&presc[`TMR0_TAP64:0]);
  assign tap_wrap[2] = presc_tick && (&presc[`TMR0_TAP256:0]);
  assign tap_wrap[3] = presc_tick && (&presc[`TMR0_TAP1024:0]);
  assign prescale_taps_out = tap_wrap;

  // Free-running shared prescaler; never reset by counter writes
  // so the second timer never sees its tap phase jump
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      presc <= 10'h000;
      half_ph <= 1'b0;
    end
    else
    begin
      half_ph <= !half_ph;
      if (presc_tick)
        presc <= presc_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; pin_s1 feeds only pin_s2
  // Resets low: a pin that idles high shows one false rising edge
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= counter0_ext_clock_pin_in;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  // Edges narrower than one clock period may be lost
  // pin_d is a third flop, so detection never reads a settling stage
  wire pin_rise = pin_s2 && !pin_d;
  wire pin_fall = !pin_s2 && pin_d;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  // Each source becomes a one-cycle enable; the counter keeps one clock
  logic count_en;
  always_comb
  begin
    case (tmr0_sel_e'(sel))
      TMR0_STOP: count_en = 1'b0;
      TMR0_CK: count_en = presc_tick;
      TMR0_CK8: count_en = tap_wrap[0];
      TMR0_CK64: count_en = tap_wrap[1];
      TMR0_CK256: count_en = tap_wrap[2];
      TMR0_CK1024: count_en = tap_wrap[3];
      TMR0_EXT_FALL: count_en = pin_fall;
      TMR0_EXT_RISE: count_en = pin_rise;
      default: count_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Holding slots let address and data arrive in either order
  // Only byte lane 0 carries register bits; other lanes are ignored
  wire wr_go = aw_full && w_full && !s_axi_bvalid_out;
  wire [7:0] wr_idx = aw_addr[9:2];
  wire [7:0] rd_idx = s_axi_araddr_in[9:2];
  wire wr_hi_zero = (aw_addr[31:10] == 22'h0) && (aw_addr[1:0] == 2'h0);
  wire rd_hi_zero = (s_axi_araddr_in[31:10] == 22'h0) && (s_axi_araddr_in[1:0] == 2'h0);
  wire wr_lane0 = w_strb[0];
  wire wr_ctrl = wr_go && wr_hi_zero && (wr_idx == `TMR0_CTRL_IDX) && wr_lane0;
  wire wr_val = wr_go && wr_hi_zero && (wr_idx == `TMR0_VALUE_IDX) && wr_lane0;
  wire wr_flag = wr_go && wr_hi_zero && (wr_idx == `TMR0_FLAG_IDX) && wr_lane0;
  wire wr_mask = wr_go && wr_hi_zero && (wr_idx == `TMR0_MASK_IDX) && wr_lane0;
  wire wr_cfg = wr_go && wr_hi_zero && (wr_idx == `TMR0_CFG_IDX) && wr_lane0;
  wire wr_hit = wr_hi_zero && ((wr_idx == `TMR0_CTRL_IDX) || (wr_idx == `TMR0_VALUE_IDX)
    || (wr_idx == `TMR0_FLAG_IDX) || (wr_idx == `TMR0_MASK_IDX) || (wr_idx == `TMR0_CFG_IDX));
  wire rd_go = s_axi_arvalid_in && !s_axi_rvalid_out;
  // A value write in the same cycle wins, so no overflow is raised then
  wire ovf_event = count_en && (counter0_value == 8'hff) && !wr_val;
  wire [7:0] cnt_inc = counter0_value + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read zero
  // Unmapped or unaligned reads answer SLVERR with zero data
  always_comb
  begin
    next_rresp = 2'b00;
    if (!rd_hi_zero)
      next_rdata = 32'h0;
    else
    begin
      case (rd_idx)
        `TMR0_CTRL_IDX: next_rdata = {29'h0, sel};
        `TMR0_VALUE_IDX: next_rdata = {24'h0, counter0_value};
        `TMR0_FLAG_IDX: next_rdata = {31'h0, flag_ovf};
        `TMR0_MASK_IDX: next_rdata = {31'h0, mask_ovf};
        `TMR0_CFG_IDX: next_rdata = {31'h0, half_mode};
        default: next_rdata = 32'h0;
      endcase
    end
    if (!rd_hi_zero || !((rd_idx == `TMR0_CTRL_IDX) || (rd_idx == `TMR0_VALUE_IDX)
      || (rd_idx == `TMR0_FLAG_IDX) || (rd_idx == `TMR0_MASK_IDX) || (rd_idx == `TMR0_CFG_IDX)))
      next_rresp = 2'b10;
  end

  // A held beat blocks the next one; reads wait for the answer to go
  assign s_axi_awready_out = !aw_full;
  assign s_axi_wready_out = !w_full;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  // Mask only gates the level; the flag records events regardless
  assign irq_out = flag_ovf && mask_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture and response
  // A response waits until both beats are held and none is pending
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_addr <= 32'h0;
      aw_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_full <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_full)
      begin
        aw_addr <= s_axi_awaddr_in;
        aw_full <= 1'b1;
      end
      if (s_axi_wvalid_in && !w_full)
      begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        w_full <= 1'b1;
      end
      // Completing a write frees both slots on the same edge
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // Read response, one cycle after the address is taken
  // The address is refused while an answer waits, so rdata stays put
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= 2'b00;
    end
    else if (rd_go)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rresp;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, counter and flag
  // Only the three select bits are stored; the rest read zero
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Reset stops the counter and masks the interrupt
      sel <= `TMR0_CTRL_RST;
      counter0_value <= `TMR0_VALUE_RST;
      flag_ovf <= 1'b0;
      mask_ovf <= 1'b0;
      half_mode <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        sel <= w_data[`TMR0_SEL_MSB:`TMR0_SEL_LSB];
      if (wr_mask)
        mask_ovf <= w_data[`TMR0_OVF_BIT];
      if (wr_cfg)
        half_mode <= w_data[`TMR0_HALF_BIT];
      // Written value wins this cycle; counting resumes on the next
      if (wr_val)
        counter0_value <= w_data[7:0];
      else if (count_en)
        counter0_value <= cnt_inc;
      // Set beats a simultaneous write-one clear
      if (ovf_event)
        flag_ovf <= 1'b1;
      else if (wr_flag && w_data[`TMR0_OVF_BIT])
        flag_ovf <= 1'b0;
    end
  end

endmodule : tmr0_timer

// ===== logic/tmr0_map.svh
`ifndef TMR0_MAP_SVH
`define TMR0_MAP_SVH
// Register index (byte address = index * 4)
`define TMR0_CTRL_IDX 8'h33
`define TMR0_VALUE_IDX 8'h32
`define TMR0_FLAG_IDX 8'h38
`define TMR0_MASK_IDX 8'h39
`define TMR0_CFG_IDX 8'h3a
// Field positions
`define TMR0_SEL_LSB 0
`define TMR0_SEL_MSB 2
`define TMR0_OVF_BIT 0
`define TMR0_HALF_BIT 0
// Reset values
`define TMR0_CTRL_RST 3'h0
`define TMR0_VALUE_RST 8'h00
// Prescaler taps (bit index of the 10-bit prescaler that wraps)
`define TMR0_TAP8 2
`define TMR0_TAP64 5
`define TMR0_TAP256 7
`define TMR0_TAP1024 9
`endif

// ===== logic/tmr0_pkg.sv
package tmr0_pkg;
  typedef enum logic [2:0]
  {
    TMR0_STOP = 3'b000,
    TMR0_CK = 3'b001,
    TMR0_CK8 = 3'b010,
    TMR0_CK64 = 3'b011,
    TMR0_CK256 = 3'b100,
    TMR0_CK1024 = 3'b101,
    TMR0_EXT_FALL = 3'b110,
    TMR0_EXT_RISE = 3'b111
  } tmr0_sel_e;
endpackage : tmr0_pkg

// ===== tb/tmr0_monitor.sv
module tmr0_monitor (
  // Clock, reset and taps
  input wire logic core_clk_in, rst_in,
  input wire logic [3:0] prescale_taps_out,
  // Bus handshakes
  input wire logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out,
  input wire logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out,
  input wire logic s_axi_rvalid_out, s_axi_rready_in,
  input wire logic [31:0] s_axi_araddr_in, s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bad_addr;
  logic ar_hs;
  // Only the five register words are mapped
  assign bad_addr = !(s_axi_araddr_in inside {32'hcc, 32'hc8, 32'he0, 32'he4, 32'he8});
  // Read address handshake as one signal, so the past value is a plain net
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence rd_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  ////////////////////////////////////////
  tap_nest_a: assert property (!(|(prescale_taps_out[3:1] & ~prescale_taps_out[2:0])))
    else $error("long tap without short tap");
  tap_gap_a: assert property (prescale_taps_out[0] |=> (!prescale_taps_out[0]) [*7])
    else $error("short tap too frequent");
  // Both beats are held on the next edge, the response registered on the one after
  wr_ans_a: assert property (wr_take |-> ##2 s_axi_bvalid_out)
    else $error("no write response");
  rd_ans_a: assert property (rd_take |=> s_axi_rvalid_out)
    else $error("no read response");
  rd_err_a: assert property (rd_take ##0 bad_addr |=>
    s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 0)
    else $error("unmapped read not refused");
  rd_cause_a: assert property ($rose(s_axi_rvalid_out) |-> $past(ar_hs))
    else $error("read answer without a request");
  b_drop_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response stuck");
  r_drop_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read response stuck");
endmodule : tmr0_monitor

bind tmr0_timer tmr0_monitor monitor (.*);

// ===== tb/tmr0_pin_src.sv
module tmr0_pin_src (
  // Control
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [7:0] edges_in,
  // Pin side
  output logic pin_out = 1'b0,
  output logic busy_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Three cycles per level, well above the one-period minimum
  always @(posedge clk_in)
    if (start_in && !busy_out)
    begin
      busy_out <= 1;
      repeat (edges_in)
      begin
        repeat (3) @(posedge clk_in);
        pin_out <= ~pin_out;
      end
      @(posedge clk_in);
      busy_out <= 0;
    end
endmodule : tmr0_pin_src

// ===== tb/timer0_with_prescaler_bench.sv
module timer0_with_prescaler_bench import tmr0_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTL = 32'hcc, VAL = 32'hc8, FLG = 32'he0, MSK = 32'he4, CFG = 32'he8;
  logic [31:0] ra[4] = '{CTL, VAL, FLG, MSK};
  logic core_clk_in = 0, rst_in = 1, go = 0, busy, counter0_ext_clock_pin_in;
  logic [31:0] s_axi_awaddr_in = 0, s_axi_wdata_in = 0, s_axi_araddr_in = 0, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in = 4'hf, prescale_taps_out;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  int error_cnt = 0, checked = 0, tc[4], dv[4] = '{8, 64, 256, 1024};
  always #4 core_clk_in = ~core_clk_in;
  tmr0_timer DUT (.*);
  tmr0_pin_src SRC (.clk_in(core_clk_in), .start_in(go), .edges_in(8'h0b),
    .pin_out(counter0_ext_clock_pin_in), .busy_out(busy));
  ////////////////////////////////////////
  task test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task tmo;
    $display("Error timeout expected 1 seen 0");
    error_cnt++;
    test_done();
  endtask : tmo
  // Handshake flags sampled at negedge, acted on at the next rising edge;
  // each call first lets an edge pass so no ready or valid is set twice at once
  task wr(input logic [31:0] a, v);
    logic ta, tw, tb;
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    tb = 0;
    for (int i = 0; i < 50 && !tb; i++)
    begin
      @(negedge core_clk_in);
      ta = s_axi_awready_out;
      tw = s_axi_wready_out;
      tb = s_axi_bvalid_out;
      resp = s_axi_bresp_out;
      @(posedge core_clk_in);
      if (ta) s_axi_awvalid_in <= 0;
      if (tw) s_axi_wvalid_in <= 0;
    end
    s_axi_bready_in <= 0;
    if (!tb) tmo();
  endtask : wr
  task rd(input logic [31:0] a);
    logic ta, tv;
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    tv = 0;
    for (int i = 0; i < 50 && !tv; i++)
    begin
      @(negedge core_clk_in);
      ta = s_axi_arready_out;
      tv = s_axi_rvalid_out;
      d = s_axi_rdata_out;
      resp = s_axi_rresp_out;
      @(posedge core_clk_in);
      if (ta) s_axi_arvalid_in <= 0;
    end
    s_axi_rready_in <= 0;
    if (!tv) tmo();
  endtask : rd
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 0;
    @(posedge core_clk_in);
    foreach (ra[k])
    begin
      rd(ra[k]);
      chk("reset value", 0, d);
    end
    chk("irq reset", 0, irq_out);
    wr(CTL, 32'hff);
    chk("write resp", 0, resp);
    rd(CTL);
    chk("control", 32'h7, d);
    rd(32'h10);
    chk("unmapped", 32'h2, resp);
    wr(32'h10, 1);
    chk("unmapped write", 32'h2, resp);
    wr(CTL, TMR0_STOP);
    wr(VAL, 32'h10);
    repeat (40) @(posedge core_clk_in);
    rd(VAL);
    chk("stopped", 32'h10, d);
    wr(CTL, TMR0_CK);
    wr(VAL, 32'h80);
    rd(VAL);
    // Written at the response edge, two ticks pass before the read takes the value
    chk("resumed", 32'h82, d);
    $display("test basic done");
    // Eight periods of each tap give a count of eight or nine
    foreach (dv[k])
    begin
      wr(CTL, TMR0_CK8 + k);
      wr(VAL, 0);
      repeat (8 * dv[k]) @(posedge core_clk_in);
      rd(VAL);
      chk("divided", 1, d == 8 || d == 9);
    end
    // Tap pulse counts are phase free over whole periods
    for (int h = 0; h < 2; h++)
    begin
      wr(CFG, h);
      tc = '{default: 0};
      repeat (1024 << h)
      begin
        @(negedge core_clk_in);
        foreach (tc[i]) tc[i] += prescale_taps_out[i];
      end
      foreach (tc[i]) chk("taps", 128 / (dv[i] / 8), tc[i]);
    end
    wr(CFG, 0);
    $display("test prescaler done");
    wr(CTL, TMR0_STOP);
    wr(FLG, 1);
    wr(MSK, 0);
    wr(VAL, 32'hfe);
    wr(CTL, TMR0_CK);
    wr(CTL, TMR0_STOP);
    rd(FLG);
    chk("flag", 1, d);
    chk("masked", 0, irq_out);
    wr(MSK, 1);
    @(negedge core_clk_in);
    chk("irq", 1, irq_out);
    wr(FLG, 1);
    rd(FLG);
    chk("cleared", 0, d);
    chk("irq low", 0, irq_out);
    $display("test overflow done");
    // Pin ends high after the first run, so each run sees five chosen edges
    for (int m = 0; m < 2; m++)
    begin
      wr(CTL, TMR0_EXT_FALL + m);
      wr(VAL, 0);
      go <= 1;
      @(posedge core_clk_in);
      go <= 0;
      @(negedge core_clk_in);
      for (int n = 0; n < 100 && busy !== 0; n++) @(negedge core_clk_in);
      if (busy !== 0) tmo();
      repeat (4) @(posedge core_clk_in);
      rd(VAL);
      chk("pin edges", 5, d);
    end
    $display("test pin done");
    test_done();
  end
endmodule : timer0_with_prescaler_bench
